// ===== core/isp_flash_ctrl.sv
// Notes on behaviour
// - Key 87h arms for three machine cycles; 59h then opens three-cycle window.
// - Chip control and clock config writes are dropped unless the window is open.
// - Second key arriving after arm time expires opens nothing; guarded writes fail.
// - Guarded write after the window closed leaves the bit unchanged.
// - Chip control is read-only from reset until the two keys unlock it.
// - Any other value written to the unlock register closes write permission.
// - Chip control bit 0 set means programming mode on next wake from idle.
// - That wake selects loader bank, clears PC and pushes zero to stack.
// - First return from interrupt then lands at loader address zero.
// - Writing bits 0, 1 and 7 set resets the CPU back to application bank.
// - Flash address sits in high and low byte registers; data in its own.
// - Command bit 6 picks bank: 0 application, 1 loader; bit 7 reserved.
// - Command bit 5 output enable, bit 4 chip enable, bits 3..0 opcode.
// - Opcodes: erase 0010, program 0001, read 0000; read returns data.
// - After power-on reset code runs from the application bank.
// - Straps low with matching option bit low boot from the loader bank.
// - Lock option low refuses flash and option bit access.
// - Read inhibit low confines external code reads to external memory.
// - Encryption encodes port 0 data; an application bank erase command or a system reset clears it.
// - Option bit 7 low halves oscillator gain.
module isp_flash_ctrl #(
  parameter int CLKS_PER_MC = isp_pkg::ISP_CLKS_PER_MC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_idle,
  input  wire logic        boot_strap_a,
  input  wire logic        boot_strap_b,
  input  wire logic        boot_strap_c,
  input  wire logic [7:0]  option_bits,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_rdata_valid,
  output logic             flash_cmd_strobe,
  output logic      [15:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  output logic      [3:0]  flash_op,
  output logic             flash_output_enable,
  output logic             flash_chip_enable,
  output logic             target_bank_select,
  output logic      [7:0]  clock_config_reg,
  output logic             fetch_from_loader,
  output logic             isp_mode,
  output logic             pc_clear,
  output logic             stack_push_zero,
  output logic             cpu_soft_reset,
  output logic             code_memory_read_external_only,
  output logic             encrypt_enable,
  output logic             osc_half_gain
);

  function automatic logic isp_hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction : isp_hit

  logic        pready_reg;
  logic        pslverr_reg;
  logic [7:0]  prdata_reg;
  logic [7:0]  chip_ctrl_reg;
  logic [7:0]  clk_cfg_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  addr_hi_reg;
  logic [7:0]  addr_lo_reg;
  logic [7:0]  data_reg;
  logic [7:0]  opt_reg;
  logic        strobe_reg;
  logic        loader_reg;
  logic        isp_reg;
  logic        pc_clear_reg;
  logic        push_reg;
  logic        srst_reg;
  logic        idle_d_reg;
  logic        boot_done_reg;
  logic [2:0]  boot_cnt_reg;
  logic        enc_reg;
  logic        code_memory_read_reg;
  logic        osc_reg;
  logic [2:0]  straps;
  logic        window_open;

  // Bus decode. The answer takes one wait state so that read data is registered.
  wire access_phase = psel & penable;
  wire answer_now   = access_phase & ~pready_reg;
  wire done         = access_phase & pready_reg;
  wire hit_unlock   = isp_hit(paddr, isp_pkg::ISP_IDX_UNLOCK);
  wire hit_cmd      = isp_hit(paddr, isp_pkg::ISP_IDX_CMD);
  wire hit_ahi      = isp_hit(paddr, isp_pkg::ISP_IDX_ADDR_HI);
  wire hit_alo      = isp_hit(paddr, isp_pkg::ISP_IDX_ADDR_LO);
  wire hit_data     = isp_hit(paddr, isp_pkg::ISP_IDX_DATA);
  wire hit_chip     = isp_hit(paddr, isp_pkg::ISP_IDX_CHIP_CTRL);
  wire hit_clk      = isp_hit(paddr, isp_pkg::ISP_IDX_CLK_CFG);
  wire hit_opt      = isp_hit(paddr, isp_pkg::ISP_IDX_OPTION);
  wire hit_stat     = isp_hit(paddr, isp_pkg::ISP_IDX_STATUS);
  wire hit_any      = hit_unlock | hit_cmd | hit_ahi | hit_alo | hit_data
                    | hit_chip | hit_clk | hit_opt | hit_stat;
  wire wr           = done & pwrite;
  wire [7:0] wbyte  = pwdata[7:0];

  wire lock_active  = boot_done_reg & ~opt_reg[isp_pkg::ISP_OPT_LOCK];
  wire key_write    = wr & hit_unlock;
  wire wr_chip      = wr & hit_chip & window_open;
  wire wr_clk       = wr & hit_clk & window_open;
  wire wr_cmd       = wr & hit_cmd & ~lock_active;
  wire soft_reset   = wr_chip
                    & ((wbyte & isp_pkg::ISP_SOFT_RESET_MASK) == isp_pkg::ISP_SOFT_RESET_MASK);
  wire wake         = idle_d_reg & ~cpu_idle;
  wire isp_enter    = wake & chip_ctrl_reg[isp_pkg::ISP_CHIP_ISP_EN] & ~isp_reg;
  wire capture      = ~boot_done_reg & (boot_cnt_reg == isp_pkg::ISP_STRAP_SETTLE);
  wire erase_app    = wr_cmd & (wbyte[3:0] == isp_pkg::ISP_OP_ERASE)
                    & ~wbyte[isp_pkg::ISP_CMD_BANK];

  // Strap a and b with option bit 4 low, or strap c with option bit 5 low.
  wire boot_p2      = ~straps[0] & ~straps[1] & ~option_bits[isp_pkg::ISP_OPT_BOOT_P2];
  wire boot_p4      = ~straps[2] & ~option_bits[isp_pkg::ISP_OPT_BOOT_P4];
  wire boot_loader  = boot_p2 | boot_p4;

  wire [7:0] status = {3'b000, lock_active, boot_done_reg, window_open, loader_reg, isp_reg};
  wire [7:0] opt_view = lock_active ? 8'h00 : opt_reg;
  wire [7:0] rd_mux = hit_cmd  ? {1'b0, cmd_reg[6:0]} :
                      hit_ahi  ? addr_hi_reg :
                      hit_alo  ? addr_lo_reg :
                      hit_data ? data_reg :
                      hit_chip ? chip_ctrl_reg :
                      hit_clk  ? clk_cfg_reg :
                      hit_opt  ? opt_view :
                      hit_stat ? status : 8'h00;

  wire [7:0] chip_next = soft_reset ? isp_pkg::ISP_CHIP_CTRL_RST :
                         wr_chip    ? wbyte : chip_ctrl_reg;
  wire loader_next = isp_enter  ? 1'b1 :
                     soft_reset ? 1'b0 :
                     capture    ? boot_loader : loader_reg;

  isp_unlock #(
    .CLKS_PER_MC (CLKS_PER_MC)
  ) u_unlock (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .key_write   (key_write),
    .key_data    (wbyte),
    .window_open (window_open)
  );

  isp_pin_sync #(
    .WIDTH (3)
  ) u_straps (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({boot_strap_c, boot_strap_b, boot_strap_a}),
    .pin_out (straps)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 8'h00;
    end else begin
      pready_reg  <= answer_now;
      pslverr_reg <= answer_now & ~hit_any;
      prdata_reg  <= (answer_now & ~pwrite) ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chip_ctrl_reg <= isp_pkg::ISP_CHIP_CTRL_RST;
      clk_cfg_reg   <= isp_pkg::ISP_CLK_CFG_RST;
    end else begin
      chip_ctrl_reg <= chip_next;
      clk_cfg_reg   <= wr_clk ? wbyte : clk_cfg_reg;
    end
  end

  // Flash data: a returning read wins over a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reg     <= isp_pkg::ISP_CMD_RST;
      addr_hi_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      data_reg    <= 8'h00;
      strobe_reg  <= 1'b0;
    end else begin
      cmd_reg     <= wr_cmd ? {1'b0, wbyte[6:0]} : cmd_reg;
      addr_hi_reg <= (wr & hit_ahi) ? wbyte : addr_hi_reg;
      addr_lo_reg <= (wr & hit_alo) ? wbyte : addr_lo_reg;
      data_reg    <= flash_rdata_valid ? flash_rdata :
                     (wr & hit_data) ? wbyte : data_reg;
      strobe_reg  <= wr_cmd;
    end
  end

  // Options are latched once the straps have settled after release.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_cnt_reg  <= 3'h0;
      boot_done_reg <= 1'b0;
      opt_reg       <= isp_pkg::ISP_OPT_RST;
      loader_reg    <= 1'b0;
    end else begin
      boot_cnt_reg  <= boot_done_reg ? boot_cnt_reg : boot_cnt_reg + 3'h1;
      boot_done_reg <= boot_done_reg | capture;
      opt_reg       <= capture ? option_bits : opt_reg;
      loader_reg    <= loader_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_d_reg   <= 1'b0;
      isp_reg      <= 1'b0;
      pc_clear_reg <= 1'b0;
      push_reg     <= 1'b0;
      srst_reg     <= 1'b0;
    end else begin
      idle_d_reg   <= cpu_idle;
      isp_reg      <= isp_enter | (isp_reg & ~soft_reset);
      pc_clear_reg <= isp_enter;
      push_reg     <= isp_enter;
      srst_reg     <= soft_reset;
    end
  end

  // Encryption is sticky: a reload cannot switch it off, only an application erase or a system reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enc_reg  <= 1'b0;
      code_memory_read_reg <= 1'b0;
      osc_reg  <= 1'b0;
    end else begin
      enc_reg  <= (capture & ~option_bits[isp_pkg::ISP_OPT_ENC])
                | (enc_reg & ~erase_app);
      code_memory_read_reg <= boot_done_reg & ~opt_reg[isp_pkg::ISP_OPT_CODE_MEMORY_READ];
      osc_reg  <= boot_done_reg & ~opt_reg[isp_pkg::ISP_OPT_OSC];
    end
  end

  assign prdata              = {24'h0000_00, prdata_reg};
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign flash_cmd_strobe    = strobe_reg;
  assign flash_addr          = {addr_hi_reg, addr_lo_reg};
  assign flash_wdata         = data_reg;
  assign flash_op            = cmd_reg[3:0];
  assign flash_output_enable = cmd_reg[isp_pkg::ISP_CMD_OE];
  assign flash_chip_enable   = cmd_reg[isp_pkg::ISP_CMD_CE];
  assign target_bank_select  = cmd_reg[isp_pkg::ISP_CMD_BANK];
  assign clock_config_reg    = clk_cfg_reg;
  assign fetch_from_loader   = loader_reg;
  assign isp_mode            = isp_reg;
  assign pc_clear            = pc_clear_reg;
  assign stack_push_zero     = push_reg;
  assign cpu_soft_reset      = srst_reg;
  assign code_memory_read_external_only  = code_memory_read_reg;
  assign encrypt_enable      = enc_reg;
  assign osc_half_gain       = osc_reg;

  guard_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr && (hit_chip || hit_clk) && !window_open
      |=> $stable(chip_ctrl_reg) && $stable(clk_cfg_reg)
  ) else $error("guarded register changed with window closed");

  isp_entry_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    isp_enter |=> isp_mode && fetch_from_loader && pc_clear && stack_push_zero
      ##1 !pc_clear && !stack_push_zero
  ) else $error("wake into programming mode incomplete");

  soft_reset_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    soft_reset && !isp_enter |=> cpu_soft_reset && !fetch_from_loader && !isp_mode
  ) else $error("software reset did not return to application bank");

  lock_refuse_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr && hit_cmd && lock_active |=> !flash_cmd_strobe && $stable(cmd_reg)
  ) else $error("locked device accepted a flash command");

  cmd_fields_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_cmd |=> flash_cmd_strobe && flash_op == $past(wbyte[3:0])
      && target_bank_select == $past(wbyte[isp_pkg::ISP_CMD_BANK])
  ) else $error("flash command fields not driven from the written byte");

  gain_option_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    boot_done_reg && $stable(opt_reg) |=> osc_half_gain == !opt_reg[isp_pkg::ISP_OPT_OSC]
  ) else $error("oscillator gain does not follow option bit");
endmodule : isp_flash_ctrl

// ===== core/isp_pkg.sv
package isp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] ISP_IDX_UNLOCK    = 10'h0F6;
  localparam logic [9:0] ISP_IDX_CMD       = 10'h0C7;
  localparam logic [9:0] ISP_IDX_ADDR_HI   = 10'h0C4;
  localparam logic [9:0] ISP_IDX_ADDR_LO   = 10'h0C5;
  localparam logic [9:0] ISP_IDX_DATA      = 10'h0C6;
  localparam logic [9:0] ISP_IDX_CHIP_CTRL = 10'h0A0;
  localparam logic [9:0] ISP_IDX_CLK_CFG   = 10'h0A1;
  localparam logic [9:0] ISP_IDX_OPTION    = 10'h0A2;
  localparam logic [9:0] ISP_IDX_STATUS    = 10'h0A3;

  localparam logic [7:0] ISP_KEY_FIRST  = 8'h87;
  localparam logic [7:0] ISP_KEY_SECOND = 8'h59;

  localparam int ISP_KEY_EXPIRE_MC = 3;
  localparam int ISP_WINDOW_MC     = 3;
  localparam int ISP_CLKS_PER_MC   = 12;
  localparam logic [2:0] ISP_STRAP_SETTLE = 3'h6;

  localparam int ISP_CHIP_ISP_EN = 0;
  localparam logic [7:0] ISP_SOFT_RESET_MASK = 8'h83;

  localparam int ISP_CMD_BANK = 6;
  localparam int ISP_CMD_OE   = 5;
  localparam int ISP_CMD_CE   = 4;
  localparam logic [3:0] ISP_OP_READ    = 4'h0;
  localparam logic [3:0] ISP_OP_PROGRAM = 4'h1;
  localparam logic [3:0] ISP_OP_ERASE   = 4'h2;

  localparam int ISP_OPT_LOCK    = 1;
  localparam int ISP_OPT_CODE_MEMORY_READ    = 2;
  localparam int ISP_OPT_ENC     = 3;
  localparam int ISP_OPT_BOOT_P2 = 4;
  localparam int ISP_OPT_BOOT_P4 = 5;
  localparam int ISP_OPT_OSC     = 7;

  localparam logic [7:0] ISP_CHIP_CTRL_RST = 8'h00;
  localparam logic [7:0] ISP_CLK_CFG_RST   = 8'h00;
  localparam logic [7:0] ISP_CMD_RST       = 8'h10;
  localparam logic [7:0] ISP_OPT_RST       = 8'hFF;

  typedef enum logic [2:0] {
    ISP_TA_CLOSED = 3'b001,
    ISP_TA_ARMED  = 3'b010,
    ISP_TA_OPEN   = 3'b100
  } isp_ta_state_t;

endpackage : isp_pkg

// ===== core/isp_pin_sync.sv
module isp_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] out_reg;
  wire  [WIDTH-1:0] agree = ~(ff2_reg ^ ff3_reg);
  wire  [WIDTH-1:0] out_next = (agree & ff3_reg) | (~agree & out_reg);

  // Straps idle high, so reset assumes the released state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ff1_reg <= '1;
      ff2_reg <= '1;
      ff3_reg <= '1;
      out_reg <= '1;
    end else begin
      ff1_reg <= pin_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;
endmodule : isp_pin_sync

// ===== core/isp_unlock.sv
module isp_unlock #(
  parameter int CLKS_PER_MC = isp_pkg::ISP_CLKS_PER_MC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       key_write,
  input  wire logic [7:0] key_data,
  output logic            window_open
);
  localparam int ARM_CLKS = isp_pkg::ISP_KEY_EXPIRE_MC * CLKS_PER_MC;
  localparam int WIN_CLKS = isp_pkg::ISP_WINDOW_MC * CLKS_PER_MC;
  localparam int CW       = $clog2(ARM_CLKS + WIN_CLKS + 1);

  isp_pkg::isp_ta_state_t state_reg;
  isp_pkg::isp_ta_state_t state_next;
  logic [CW-1:0]          cnt_reg;
  logic [CW-1:0]          cnt_next;
  logic [CW-1:0]          open_cnt_reg;

  wire is_first  = key_data == isp_pkg::ISP_KEY_FIRST;
  wire is_second = key_data == isp_pkg::ISP_KEY_SECOND;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (key_write) begin
      if (is_first) begin
        state_next = isp_pkg::ISP_TA_ARMED;
        cnt_next   = CW'(ARM_CLKS - 1);
      end else if (is_second && state_reg == isp_pkg::ISP_TA_ARMED) begin
        state_next = isp_pkg::ISP_TA_OPEN;
        cnt_next   = CW'(WIN_CLKS - 1);
      end else begin
        state_next = isp_pkg::ISP_TA_CLOSED;
        cnt_next   = '0;
      end
    end else begin
      unique case (state_reg)
        isp_pkg::ISP_TA_CLOSED: begin
          cnt_next = '0;
        end
        isp_pkg::ISP_TA_ARMED, isp_pkg::ISP_TA_OPEN: begin
          if (cnt_reg == '0) begin
            state_next = isp_pkg::ISP_TA_CLOSED;
          end else begin
            cnt_next = cnt_reg - CW'(1);
          end
        end
        default: begin
          state_next = isp_pkg::ISP_TA_CLOSED;
          cnt_next   = '0;
        end
      endcase
    end
  end

  // System reset closes the scheme, a software reset does not; counting is in core clocks per machine cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= isp_pkg::ISP_TA_CLOSED;
      cnt_reg      <= '0;
      open_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      open_cnt_reg <= (state_next == isp_pkg::ISP_TA_OPEN) ? open_cnt_reg + CW'(1) : '0;
    end
  end

  assign window_open = state_reg == isp_pkg::ISP_TA_OPEN;

  key_opens_window_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    key_write && is_second && state_reg == isp_pkg::ISP_TA_ARMED |=> window_open
  ) else $error("second key inside arm time did not open window");

  window_length_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    open_cnt_reg <= CW'(WIN_CLKS)
  ) else $error("write window stayed open too long");

  bad_key_closes_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    key_write && !is_first && !(is_second && state_reg == isp_pkg::ISP_TA_ARMED)
      |=> !window_open
  ) else $error("foreign key value left window open");

  late_key_fails_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == isp_pkg::ISP_TA_ARMED && cnt_reg == '0 && !key_write
      |=> state_reg == isp_pkg::ISP_TA_CLOSED ##1 !window_open
  ) else $error("arm time did not expire");
endmodule : isp_unlock

// ===== verif/isp_flash_model.sv
module isp_flash_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        flash_cmd_strobe,
  input  wire logic [15:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic [3:0]  flash_op,
  input  wire logic        flash_output_enable,
  input  wire logic        flash_chip_enable,
  input  wire logic        target_bank_select,
  output logic      [7:0]  flash_rdata,
  output logic             flash_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_bank [2][256];
  logic [1:0] delay_reg;
  logic       pending_reg;
  logic [8:0] rd_sel_reg;
  // Reads answer late on purpose, and the data bus is inverted while idle so stale data shows.
  always_ff @(posedge clk) begin
    flash_rdata_valid <= 1'b0;
    if (sys_rst) begin
      pending_reg <= 1'b0;
      flash_rdata <= 8'h00;
    end else if (flash_cmd_strobe && !flash_chip_enable) begin
      case (flash_op)
        isp_pkg::ISP_OP_ERASE: if (flash_output_enable) begin
          for (int i = 0; i < 256; i++) mem_bank[target_bank_select][i] <= 8'hFF;
        end
        isp_pkg::ISP_OP_PROGRAM: if (flash_output_enable) begin
          mem_bank[target_bank_select][flash_addr[7:0]] <= flash_wdata;
        end
        isp_pkg::ISP_OP_READ: if (!flash_output_enable) begin
          pending_reg <= 1'b1;
          delay_reg   <= 2'h2;
          rd_sel_reg  <= {target_bank_select, flash_addr[7:0]};
        end
        default: flash_rdata <= ~flash_rdata;
      endcase
    end else if (pending_reg && delay_reg == 2'h0) begin
      pending_reg       <= 1'b0;
      flash_rdata_valid <= 1'b1;
      flash_rdata       <= mem_bank[rd_sel_reg[8]][rd_sel_reg[7:0]];
    end else begin
      delay_reg   <= delay_reg - 2'h1;
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : isp_flash_model

// ===== verif/tb_isp_flash_control_and_boot.sv
module tb_isp_flash_control_and_boot;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MC = 4;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_idle;
  logic        boot_strap_a, boot_strap_b, boot_strap_c, flash_rdata_valid, flash_cmd_strobe;
  logic        flash_output_enable, flash_chip_enable, target_bank_select, fetch_from_loader;
  logic        isp_mode, pc_clear, stack_push_zero, cpu_soft_reset, code_memory_read_external_only;
  logic        encrypt_enable, osc_half_gain, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  option_bits, flash_rdata, flash_wdata, clock_config_reg, cmd;
  logic [15:0] flash_addr;
  logic [3:0]  flash_op;
  logic [3:0]  ops [3];
  int          mismatches, compares, hits;

  isp_flash_ctrl #(.CLKS_PER_MC(MC)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .boot_strap_a(boot_strap_a), .boot_strap_b(boot_strap_b),
    .boot_strap_c(boot_strap_c), .option_bits(option_bits), .flash_rdata(flash_rdata),
    .flash_rdata_valid(flash_rdata_valid), .flash_cmd_strobe(flash_cmd_strobe),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_op(flash_op),
    .flash_output_enable(flash_output_enable), .flash_chip_enable(flash_chip_enable),
    .target_bank_select(target_bank_select), .clock_config_reg(clock_config_reg),
    .fetch_from_loader(fetch_from_loader), .isp_mode(isp_mode), .pc_clear(pc_clear),
    .stack_push_zero(stack_push_zero), .cpu_soft_reset(cpu_soft_reset),
    .code_memory_read_external_only(code_memory_read_external_only), .encrypt_enable(encrypt_enable),
    .osc_half_gain(osc_half_gain));

  isp_flash_model flash_model (
    .clk(clk), .sys_rst(sys_rst), .flash_cmd_strobe(flash_cmd_strobe),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_op(flash_op),
    .flash_output_enable(flash_output_enable), .flash_chip_enable(flash_chip_enable),
    .target_bank_select(target_bank_select), .flash_rdata(flash_rdata),
    .flash_rdata_valid(flash_rdata_valid));

  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0000_00, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      results();
    end
  endtask : apb

  // Pulses: 0 entry, 1 software reset, 2 command strobe.
  function automatic logic pick(input int k);
    return (k == 0) ? pc_clear : (k == 1) ? cpu_soft_reset : flash_cmd_strobe;
  endfunction : pick

  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      chk("pulse", 32'h1, 32'h0);
      results();
    end
  endtask : wait_for

  task automatic unlock(input int gap);
    apb(1'b1, isp_pkg::ISP_IDX_UNLOCK, isp_pkg::ISP_KEY_FIRST);
    repeat (gap) @(posedge clk);
    apb(1'b1, isp_pkg::ISP_IDX_UNLOCK, isp_pkg::ISP_KEY_SECOND);
  endtask : unlock

  task automatic gwrite(input logic [7:0] v);
    apb(1'b1, isp_pkg::ISP_IDX_CLK_CFG, v);
    @(posedge clk);
  endtask : gwrite

  task automatic do_reset(input logic [7:0] opt, input logic [2:0] straps);
    sys_rst      <= 1'b1;
    option_bits  <= opt;
    {boot_strap_c, boot_strap_b, boot_strap_a} <= straps;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : do_reset

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    chk("run_time", 32'h1, 32'h0);
    results();
  end

  initial begin
    {sys_rst, psel, penable, pwrite, cpu_idle, paddr, pwdata} = '0;
    {boot_strap_a, boot_strap_b, boot_strap_c, option_bits} = '1;
    mismatches = 0;
    compares = 0;
    ops = '{isp_pkg::ISP_OP_ERASE, isp_pkg::ISP_OP_PROGRAM, isp_pkg::ISP_OP_READ};
    do_reset(8'hFF, 3'h7);
    chk("fetch_from_loader", 32'h0, {31'h0, fetch_from_loader});
    chk("osc_half_gain", 32'h0, {31'h0, osc_half_gain});
    apb(1'b0, 10'h3FF, 8'h00);
    chk("unmapped pslverr", 32'h1, {31'h0, err});
    apb(1'b1, isp_pkg::ISP_IDX_CHIP_CTRL, 8'h01);
    apb(1'b0, isp_pkg::ISP_IDX_CHIP_CTRL, 8'h00);
    chk("chip control", 32'h0, rd);
    gwrite(8'h5A);
    chk("clock_config_reg", 32'h0, {24'h0, clock_config_reg});
    $display("test locked_after_reset done");
    // Key commits lie gap + 4 clocks apart: gap 8 is three machine cycles, gap 12 is four.
    for (int g = 7; g <= 8; g++) begin
      unlock(g);
      gwrite(8'h10 + 8'(g));
      chk("clock_config_reg", 32'h10 + g, {24'h0, clock_config_reg});
    end
    unlock(12);
    gwrite(8'h33);
    chk("clock_config_reg", 32'h18, {24'h0, clock_config_reg});
    unlock(0);
    repeat (16) @(posedge clk);
    gwrite(8'h44);
    chk("clock_config_reg", 32'h18, {24'h0, clock_config_reg});
    unlock(0);
    apb(1'b1, isp_pkg::ISP_IDX_UNLOCK, 8'h00);
    gwrite(8'h55);
    chk("clock_config_reg", 32'h18, {24'h0, clock_config_reg});
    $display("test timed_access done");
    unlock(0);
    apb(1'b1, isp_pkg::ISP_IDX_CHIP_CTRL, 8'h01);
    cpu_idle <= 1'b1;
    @(posedge clk);
    cpu_idle <= 1'b0;
    wait_for(0);
    chk("stack_push_zero", 32'h1, {31'h0, stack_push_zero});
    @(posedge clk);
    chk("isp entry", 32'h3, {30'h0, fetch_from_loader, isp_mode});
    $display("test isp_entry done");
    apb(1'b1, isp_pkg::ISP_IDX_ADDR_HI, 8'h12);
    apb(1'b1, isp_pkg::ISP_IDX_ADDR_LO, 8'h34);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, isp_pkg::ISP_IDX_DATA, 8'hA4 + 8'(b));
      chk("flash_addr", 32'h1234, {16'h0, flash_addr});
      for (int k = 0; k < 3; k++) begin
        if (k == 2) apb(1'b1, isp_pkg::ISP_IDX_DATA, 8'h00);
        cmd = {1'b0, b[0], ops[k] != isp_pkg::ISP_OP_READ, 1'b0, ops[k]};
        apb(1'b1, isp_pkg::ISP_IDX_CMD, cmd);
        wait_for(2);
        chk("command", {24'h0, cmd}, {25'h0, target_bank_select, flash_output_enable,
            flash_chip_enable, flash_op});
      end
      repeat (8) @(posedge clk);
      apb(1'b0, isp_pkg::ISP_IDX_DATA, 8'h00);
      chk("read data", 32'hA4 + b, rd);
    end
    $display("test flash_commands done");
    unlock(0);
    apb(1'b1, isp_pkg::ISP_IDX_CHIP_CTRL, 8'h83);
    wait_for(1);
    @(posedge clk);
    chk("after soft reset", 32'h0, {30'h0, fetch_from_loader, isp_mode});
    $display("test soft_reset done");
    do_reset(8'h61, 3'h4);
    chk("option outputs", 32'hF, {28'h0, fetch_from_loader, code_memory_read_external_only,
        encrypt_enable, osc_half_gain});
    apb(1'b0, isp_pkg::ISP_IDX_OPTION, 8'h00);
    chk("option read", 32'h0, rd);
    apb(1'b1, isp_pkg::ISP_IDX_CMD, 8'h21);
    hits = 0;
    repeat (10) begin
      @(posedge clk);
      if (flash_cmd_strobe !== 1'b0) hits++;
    end
    chk("locked strobe", 32'h0, 32'(hits));
    do_reset(8'hD7, 3'h3);
    chk("fetch_from_loader", 32'h1, {31'h0, fetch_from_loader});
    chk("encrypt_enable", 32'h1, {31'h0, encrypt_enable});
    apb(1'b1, isp_pkg::ISP_IDX_CMD, 8'h22);
    @(posedge clk);
    chk("encrypt after erase", 32'h0, {31'h0, encrypt_enable});
    $display("test boot_options done");
    results();
  end
endmodule : tb_isp_flash_control_and_boot
